// ---- inc/macacc_pkg.sv ----
// Purpose: constants and types for the mac accumulator datapath
// Assumes: 16-bit operand words from the core, 40-bit accumulator
// Notes:   opcodes are the first and third instruction bytes
package macacc_pkg;

    localparam int ACC_W = 40;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;

    // first byte: addressing form
    localparam logic [7:0] FORM_REG_PAIR = 8'ha3;
    localparam logic [7:0] FORM_REG_IND = 8'h83;
    localparam logic [7:0] FORM_IDX_IND = 8'h93;

    // third byte: operation
    localparam logic [7:0] OP_ABS_ACC = 8'h1a;
    localparam logic [7:0] OP_ABS_OPND = 8'hca;
    localparam logic [7:0] OP_ADD = 8'h02;
    localparam logic [7:0] OP_ADD2 = 8'h42;
    localparam logic [7:0] OP_CMP = 8'hc2;
    localparam logic [7:0] OP_LOAD = 8'h22;
    localparam logic [7:0] OP_SHR_RND_IMM = 8'hb2;
    localparam logic [7:0] OP_SHR_RND_REG = 8'hba;
    localparam logic [7:0] OP_SHR_IMM = 8'ha2;
    localparam logic [7:0] OP_SHR_REG = 8'haa;

    localparam logic [39:0] ACC_MOST_NEG = 40'h80_0000_0000;
    localparam logic [39:0] ACC_MAX_POS = 40'h7f_ffff_ffff;
    localparam logic [39:0] ROUND_CONST = 40'h00_0000_8000;
    localparam logic [39:0] LOW_WORD_CLR = 40'hff_ffff_0000;
    localparam logic [4:0] SHIFT_MAX = 5'h10;
    localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

    // mac status flags as one carrier
    typedef struct packed {
        logic overflow_flag;
        logic sticky_limit_flag;
        logic extension_used_flag;
        logic sticky_overflow_flag;
        logic carry_flag;
        logic zero_flag;
        logic negative_flag;
    } macacc_flags_t;

    localparam macacc_flags_t FLAGS_RESET = 7'h00;

    // one issued instruction with its operands
    typedef struct packed {
        logic [7:0] form;
        logic [7:0] opcode;
        logic [4:0] imm_count;
        logic [15:0] op1;
        logic [15:0] op2;
    } macacc_instr_t;

endpackage : macacc_pkg

// ---- rtl/macacc_alu.sv ----
// Purpose: combinational result and flag evaluation of one operation
// Assumes: operands already decoded and formed by the caller
// Notes:   pure logic, no state
`timescale 1ns/100ps
module macacc_alu (
    input  wire logic [39:0]              acc,        // current accumulator
    input  wire logic [39:0]              opnd,       // formed 40-bit operand
    input  wire logic [2:0]               op_sel,     // 0 abs,1 add,2 cmp,3 load,4 shr
    input  wire logic                     abs_opnd,   // abs takes operand, not acc
    input  wire logic                     rnd,        // rounding shift
    input  wire logic [4:0]               count,      // shift count 0..16
    input  wire logic                     sat_en,     // saturation mode bit
    input  wire macacc_pkg::macacc_flags_t flags_in,  // flags before
    output macacc_pkg::macacc_flags_t     flags_out,  // flags after
    output logic [39:0]                   result,     // accumulator after
    output logic                          acc_we      // accumulator written
);
    // extension used: bits 39..31 not all equal to sign
    function automatic logic ext_used(input logic [39:0] v);
        ext_used = !((&v[39:31]) || !(|v[39:31]));
    endfunction : ext_used

    logic [40:0] sum;
    logic [39:0] raw;
    logic [39:0] shifted;
    logic        ovf;
    logic        cry;
    logic        sat;
    logic        do_sat;

    always_comb
    begin
        flags_out = flags_in;
        sum = 41'h0;
        raw = acc;
        ovf = 1'b0;
        cry = 1'b0;
        do_sat = 1'b0;
        acc_we = 1'b1;
        shifted = 40'($signed(acc) >>> count);
        case (op_sel)
            3'd0:
            begin
                raw = abs_opnd ? (opnd[39] ? 40'(-opnd) : opnd)
                               : (acc[39] ? 40'(-acc) : acc);
                ovf = !abs_opnd && (acc == macacc_pkg::ACC_MOST_NEG);
                do_sat = 1'b1;
            end
            3'd1:
            begin
                sum = {1'b0, acc} + {1'b0, opnd};
                raw = sum[39:0];
                cry = sum[40];
                ovf = (acc[39] == opnd[39]) && (raw[39] != acc[39]);
                do_sat = 1'b1;
            end
            3'd2:
            begin
                sum = {1'b0, acc} - {1'b0, opnd};
                raw = sum[39:0];
                cry = sum[40];
                ovf = $signed(acc) < $signed(opnd);
                acc_we = 1'b0;
            end
            3'd3:
            begin
                raw = opnd;
            end
            default:
            begin
                if (rnd)
                begin
                    sum = {1'b0, shifted} + {1'b0, macacc_pkg::ROUND_CONST};
                    raw = sum[39:0] & macacc_pkg::LOW_WORD_CLR;
                    cry = sum[40];
                    ovf = !shifted[39] && sum[39];
                    do_sat = 1'b1;
                end
                else
                begin
                    raw = shifted;
                end
            end
        endcase
        // saturate on overflow or when extension holds a value beyond 32 bits
        sat = do_sat && sat_en && (ovf || ext_used(raw)) && op_sel != 3'd2;
        if (sat)
            // clamp to the 32-bit signed range, sign-extended into the extension
            result = (ovf ? !raw[39] : raw[39]) ? 40'hff_8000_0000
                                                : 40'h00_7fff_ffff;
        else
            result = raw;
        if (op_sel == 3'd2)
            result = raw;
        flags_out.overflow_flag = ovf;
        flags_out.carry_flag = cry;
        if (ovf && op_sel != 3'd2)
            flags_out.sticky_overflow_flag = 1'b1;
        if (sat)
            flags_out.sticky_limit_flag = 1'b1;
        if (op_sel == 3'd3)
            flags_out.extension_used_flag = 1'b0;
        else if (op_sel != 3'd2)
            flags_out.extension_used_flag = ext_used(result);
        flags_out.zero_flag = (result == 40'h0);
        flags_out.negative_flag = result[39];
    end

endmodule : macacc_alu

// ---- rtl/macacc_top.sv ----
// Purpose: 40-bit accumulator datapath of the mac coprocessor
// Assumes: core issues one decoded instruction per valid pulse
// Notes:   result and flags commit on the edge after issue
//
// Behaviour
// - accumulator-only abs replaces accumulator with its absolute value, byte 1a.
// - that abs sets both overflow flags on most negative input, clears carry.
// - operand abs loads abs of operand; clears overflow and carry, keeps sticky overflow.
// - operand is op1 low word, op2 high word, sign-extended to 40 bits.
// - first byte a3, 83 or 93 selects addressing form.
// - third byte 02 add, 42 doubled add, c2 compare, ca operand abs.
// - add writes accumulator plus operand; carry from the addition.
// - doubled add uses twice the operand, same flags as add.
// - add overflow flag on 40-bit signed overflow; sticky overflow set then.
// - sticky limit set when result saturates, else kept.
// - extension-used flag follows result except on compare.
// - zero flag on zero result, negative flag copies result sign.
// - shift right arithmetically by count, sign fill.
// - shift count 0..16 immediate, low four bits 0..15 otherwise.
// - rounding shift adds 8000h, clears low word, carry from rounding.
// - plain shift never saturates, clears overflow and carry, keeps sticky.
// - shift bytes b2, ba rounding; a2, aa plain.
// - compare subtracts for flags only, accumulator unchanged, no saturation.
// - compare overflow on less-than, carry on borrow, zero and negative from the difference, sticky and extension kept.
// - load writes sign-extended operand into accumulator.
// - load clears overflow, extension and carry, keeps sticky, no saturation.
// - load uses byte 22 in all three forms.
`timescale 1ns/100ps
module macacc_top (
    input  wire logic                      clock,            // core clock 200 MHz
    input  wire logic                      reset_n,          // async reset, active low
    input  wire logic                      instr_valid,      // one-cycle issue strobe
    input  wire macacc_pkg::macacc_instr_t instr,            // instruction and operands
    input  wire logic                      saturation_mode_bit, // saturate enable
    output logic                           instr_illegal,    // pulse: unknown encoding
    output logic [39:0]                    mac_accumulator,  // accumulator
    output macacc_pkg::macacc_flags_t      mac_status_word   // status flags
);
    logic [39:0]               acc_r;
    macacc_pkg::macacc_flags_t flags_r;
    logic                      ill_r;
    logic [39:0]               opnd;
    logic [2:0]                op_sel;
    logic                      abs_opnd;
    logic                      rnd;
    logic                      legal;
    logic [4:0]                count;
    logic [39:0]               acc_nxt;
    logic                      acc_we;
    macacc_pkg::macacc_flags_t flags_nxt;

    function automatic logic form_ok(input logic [7:0] f);
        form_ok = f == macacc_pkg::FORM_REG_PAIR || f == macacc_pkg::FORM_REG_IND
               || f == macacc_pkg::FORM_IDX_IND;
    endfunction : form_ok

    logic [39:0] base;
    assign base = {{8{instr.op2[15]}}, instr.op2, instr.op1};

    always_comb
    begin
        op_sel = 3'd3;
        abs_opnd = 1'b1;
        rnd = 1'b0;
        opnd = base;
        legal = form_ok(instr.form);
        count = {1'b0, instr.op1[3:0]};
        case (instr.opcode)
            macacc_pkg::OP_ABS_ACC:
            begin
                op_sel = 3'd0;
                abs_opnd = 1'b0;
                legal = instr.form == macacc_pkg::FORM_REG_PAIR;
            end
            macacc_pkg::OP_ABS_OPND: op_sel = 3'd0;
            macacc_pkg::OP_ADD: op_sel = 3'd1;
            macacc_pkg::OP_ADD2:
            begin
                op_sel = 3'd1;
                opnd = {base[38:0], 1'b0};
            end
            macacc_pkg::OP_CMP: op_sel = 3'd2;
            macacc_pkg::OP_LOAD: op_sel = 3'd3;
            macacc_pkg::OP_SHR_RND_IMM, macacc_pkg::OP_SHR_IMM:
            begin
                op_sel = 3'd4;
                rnd = instr.opcode == macacc_pkg::OP_SHR_RND_IMM;
                count = instr.imm_count;
                legal = instr.form == macacc_pkg::FORM_REG_PAIR
                     && instr.imm_count <= macacc_pkg::SHIFT_MAX;
            end
            macacc_pkg::OP_SHR_RND_REG, macacc_pkg::OP_SHR_REG:
            begin
                op_sel = 3'd4;
                rnd = instr.opcode == macacc_pkg::OP_SHR_RND_REG;
                legal = instr.form != macacc_pkg::FORM_IDX_IND && legal;
            end
            default: legal = 1'b0;
        endcase
    end

    macacc_alu u_alu (
        .acc       (acc_r),
        .opnd      (opnd),
        .op_sel    (op_sel),
        .abs_opnd  (abs_opnd),
        .rnd       (rnd),
        .count     (count),
        .sat_en    (saturation_mode_bit && op_sel != 3'd4 || rnd && saturation_mode_bit),
        .flags_in  (flags_r),
        .flags_out (flags_nxt),
        .result    (acc_nxt),
        .acc_we    (acc_we)
    );

    // flags write on every legal issue; accumulator also needs acc_we, so compare updates flags only
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_r <= macacc_pkg::ACC_RESET;
            flags_r <= macacc_pkg::FLAGS_RESET;
        end
        else if (instr_valid && legal)
        begin
            if (acc_we)
                acc_r <= acc_nxt;
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ill_r <= 1'b0;
        else
            ill_r <= instr_valid && !legal;
    end

    assign mac_accumulator = acc_r;
    assign mac_status_word = flags_r;
    assign instr_illegal = ill_r;

    sequence s_issue(logic [7:0] code);
        instr_valid && legal && instr.opcode == code;
    endsequence

    a_cmp_keeps_acc: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_CMP) |=> $stable(acc_r))
        else $error("compare changed accumulator");

    a_cmp_sticky_kept: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_CMP) |=> flags_r.sticky_overflow_flag
            == $past(flags_r.sticky_overflow_flag)
            && flags_r.extension_used_flag == $past(flags_r.extension_used_flag))
        else $error("compare touched kept flags");

    a_load_value: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_LOAD) |=> acc_r == $past(base))
        else $error("load value wrong");

    a_load_flags: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_LOAD) |=> !flags_r.overflow_flag
            && !flags_r.carry_flag && !flags_r.extension_used_flag)
        else $error("load flags not cleared");

    a_abs_most_neg: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_ABS_ACC) ##0 acc_r == macacc_pkg::ACC_MOST_NEG
            |=> flags_r.overflow_flag && flags_r.sticky_overflow_flag)
        else $error("abs most negative flags");

    a_abs_carry_clr: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_ABS_OPND) |=> !flags_r.carry_flag
            && !flags_r.overflow_flag && !flags_r.negative_flag)
        else $error("operand abs flags");

    a_shr_plain: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_SHR_IMM) |=> !flags_r.overflow_flag
            && $stable(flags_r.sticky_limit_flag) && $stable(flags_r.sticky_overflow_flag))
        else $error("plain shift flags");

    a_shr_rnd_low: assert property (@(posedge clock) disable iff (!reset_n)
        s_issue(macacc_pkg::OP_SHR_RND_IMM) |=> acc_r[15:0] == 16'h0000
            || acc_r == 40'h00_7fff_ffff)
        else $error("rounding shift low word");

    a_zero_flag: assert property (@(posedge clock) disable iff (!reset_n)
        instr_valid && legal && acc_we |=> flags_r.zero_flag == (acc_r == 40'h0)
            && flags_r.negative_flag == acc_r[39])
        else $error("zero or negative flag");

    a_illegal_hold: assert property (@(posedge clock) disable iff (!reset_n)
        instr_valid && !legal |=> $stable(acc_r) && instr_illegal)
        else $error("illegal changed state");

endmodule : macacc_top

// ---- verification/mac_accumulator_ops_test.sv ----
// Purpose: self-checking bench for the mac accumulator datapath
// Assumes: one instruction per cycle, result visible the next cycle
// Notes:   expectations come from a reference function of the bench
`timescale 1ns/100ps
module mac_accumulator_ops_test;
    logic                      clock;
    logic                      reset_n;
    logic                      sat;
    logic                      instr_valid;
    logic                      illegal;
    logic [39:0]               acc;
    logic [39:0]               e_acc;
    macacc_pkg::macacc_instr_t instr;
    macacc_pkg::macacc_flags_t flags;
    macacc_pkg::macacc_flags_t e_fl;
    int                        err_count = 0;
    int                        num_checks = 0;
    logic [7:0] ops[11] = '{8'h1a, 8'hca, 8'h02, 8'h42, 8'hc2, 8'h22,
                            8'hb2, 8'hba, 8'ha2, 8'haa, 8'h7e};
    logic [7:0] forms[4] = '{8'ha3, 8'h83, 8'h93, 8'h55};

    macacc_top u_dut (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr(instr), .saturation_mode_bit(sat), .instr_illegal(illegal),
        .mac_accumulator(acc), .mac_status_word(flags));
    macacc_core_model u_core (.instr_valid(instr_valid), .instr(instr));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    function automatic logic ref_op(macacc_pkg::macacc_instr_t i, logic s);
        logic [40:0] r;
        logic [39:0] o;
        logic        ok, ov, c, clip, cmp;
        o = {{8{i.op2[15]}}, i.op2, i.op1};
        ok = i.form inside {8'ha3, 8'h83, 8'h93};
        if (i.opcode inside {8'h1a, 8'hb2, 8'ha2}) ok &= i.form == 8'ha3;
        if (i.opcode inside {8'hb2, 8'ha2}) ok &= i.imm_count <= 5'h10;
        if (i.opcode inside {8'hba, 8'haa}) ok &= i.form != 8'h93;
        if (!(i.opcode inside {8'h1a, 8'hca, 8'h02, 8'h42, 8'hc2, 8'h22, 8'hb2, 8'hba,
                               8'ha2, 8'haa})) ok = 1'b0;
        if (!ok) return 1'b1;
        {ov, c, clip, cmp} = 4'h0;
        case (i.opcode)
            8'h1a: begin
                ov = e_acc == 40'h80_0000_0000;
                r = {1'b0, e_acc[39] ? -e_acc : e_acc};
                clip = 1'b1;
            end
            8'hca: begin
                r = {1'b0, o[39] ? -o : o};
                clip = 1'b1;
            end
            8'h02, 8'h42: begin
                o = i.opcode[6] ? {o[38:0], 1'b0} : o;
                r = {1'b0, e_acc} + {1'b0, o};
                c = r[40];
                ov = e_acc[39] == o[39] && r[39] != o[39];
                clip = 1'b1;
            end
            8'hc2: begin
                r = {1'b0, e_acc} - {1'b0, o};
                c = r[40];
                ov = $signed(e_acc) < $signed(o);
                cmp = 1'b1;
            end
            8'h22: r = {1'b0, o};
            default: begin
                r = {1'b0, 40'($signed(e_acc) >>> (i.opcode[3] ? i.op1[3:0] : i.imm_count))};
                if (i.opcode[4])
                begin
                    ov = !r[39];
                    r = r + 41'h80_00;
                    c = r[40];
                    ov &= r[39];
                    r[15:0] = 16'h0000;
                    clip = 1'b1;
                end
            end
        endcase
        // saturation direction follows the true sign, flipped by overflow
        if (clip && s && (ov || r[39:31] != {9{r[39]}}))
        begin
            r[39:0] = (r[39] ^ ov) ? 40'hff_8000_0000 : 40'h00_7fff_ffff;
            e_fl.sticky_limit_flag = 1'b1;
        end
        if (!cmp)
        begin
            e_acc = r[39:0];
            e_fl.extension_used_flag = r[39:31] != {9{r[39]}};
        end
        e_fl.overflow_flag = ov;
        e_fl.carry_flag = c;
        e_fl.sticky_overflow_flag |= ov && !cmp;
        e_fl.zero_flag = r[39:0] == 40'h0;
        e_fl.negative_flag = r[39];
        return 1'b0;
    endfunction : ref_op

    function automatic macacc_pkg::macacc_instr_t mk(logic [7:0] f, logic [7:0] op,
                                                     logic [4:0] n, logic [31:0] v);
        return '{f, op, n, v[15:0], v[31:16]};
    endfunction : mk

    task automatic bad(input string n, input logic [39:0] e, input logic [39:0] g);
        err_count++;
        $display("wrong value %s expected %h seen %h", n, e, g);
    endtask : bad

    task automatic chk_acc(input logic [39:0] e);
        num_checks++;
        if (acc !== e) bad("accumulator", e, acc);
    endtask : chk_acc

    task automatic chk_flags(input macacc_pkg::macacc_flags_t e);
        num_checks++;
        if (flags !== e) bad("status flags", 40'(e), 40'(flags));
    endtask : chk_flags

    task automatic chk_bit(input logic e);
        num_checks++;
        if (illegal !== e) bad("illegal pulse", 40'(e), 40'(illegal));
    endtask : chk_bit

    task automatic step(input macacc_pkg::macacc_instr_t i, input logic s);
        logic il;
        sat <= s;
        u_core.send(i);
        il = ref_op(i, s);
        @(negedge clock);
        chk_acc(e_acc);
        chk_flags(e_fl);
        chk_bit(il);
    endtask : step

    task automatic hold();
        u_core.idle();
        @(negedge clock);
        chk_acc(e_acc);
        chk_flags(e_fl);
        chk_bit(1'b0);
    endtask : hold

    task automatic do_reset();
        u_core.idle();
        reset_n = 1'b0;
        e_acc = 40'h0;
        e_fl = '0;
        repeat (10) @(negedge clock);
        chk_acc(40'h0);
        chk_flags(7'h00);
        chk_bit(1'b0);
        reset_n = 1'b1;
    endtask : do_reset

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    initial
    begin
        #400000;
        err_count++;
        conclude();
    end

    initial
    begin
        reset_n = 1'b0;
        sat = 1'b0;
        void'($urandom(32'hd3cf));
        @(negedge clock);
        do_reset();
        step(mk(8'ha3, 8'h22, 5'h00, 32'h8000_0001), 1'b0);
        // climb to the most negative value, then probe every overflow path
        for (int s = 0; s < 2; s++)
        begin
            step(mk(8'h83, 8'h22, 5'h00, 32'h0), 1'b0);
            repeat (128) step(mk(8'h93, 8'h42, 5'h00, 32'h8000_0000), 1'b0);
            step(mk(8'ha3, 8'hc2, 5'h00, 32'h0), 1'b1);
            step(mk(8'ha3, 8'h1a, 5'h00, 32'h0), 1'(s));
            step(mk(8'ha3, 8'h02, 5'h00, 32'hffff_ffff), 1'(s));
            step(mk(8'ha3, 8'hb2, 5'h00, 32'h0), 1'(s));
            step(mk(8'ha3, 8'ha2, 5'h10, 32'h0), 1'b1);
            step(mk(8'h83, 8'hca, 5'h00, 32'h8000_0000), 1'(s));
        end
        do_reset();
        for (int k = 0; k < 2000; k++)
        begin
            if ($urandom_range(7) == 0)
                hold();
            else
                step(mk(forms[$urandom_range(3)], ops[$urandom_range(10)],
                        5'($urandom_range(20)), $urandom), 1'($urandom));
        end
        conclude();
    end
endmodule : mac_accumulator_ops_test

// ---- verification/macacc_core_model.sv ----
// Purpose: core-side issuer of coprocessor instructions and operands
// Assumes: bench calls send or idle just after a falling edge
// Notes:   idle flips the operand bits so stale words never pass as valid
`timescale 1ns/100ps
module macacc_core_model (
    output logic                      instr_valid, // issue strobe
    output macacc_pkg::macacc_instr_t instr        // issued word
);
    initial
    begin
        instr_valid = 1'b0;
        instr       = '0;
    end

    // shift counts are chosen by the caller and passed as given, immediate up to 20 from the bench, 0..15 register
    task send(input macacc_pkg::macacc_instr_t i);
        instr_valid <= 1'b1;
        instr       <= i;
    endtask : send

    task idle();
        instr_valid <= 1'b0;
        instr       <= ~instr;
    endtask : idle
endmodule : macacc_core_model
